// >>> logic/fbo_defs.vh
// object indices, subindices, field positions and reset values of the fieldbus/host motion bank
// assumes object-dictionary access by 16-bit index and 8-bit subindex
`ifndef FBO_DEFS_VH
`define FBO_DEFS_VH
`define FBO_IDX_FB_STATUS 16'h2103
`define FBO_IDX_SLAVE_STATE 16'h2110
`define FBO_IDX_HM_ENABLE 16'h2290
`define FBO_IDX_HM_INPUT 16'h2291
`define FBO_SUB_HIGHEST 8'h00
`define FBO_SUB_1 8'h01
`define FBO_SUB_2 8'h02
`define FBO_SUB_3 8'h03
`define FBO_SUB_4 8'h04
`define FBO_FB_STATUS_MAXSUB 8'h02
`define FBO_HM_INPUT_MAXSUB 8'h04
`define FBO_DEACT_MASK_RST 32'h00000000
`define FBO_ACTIVE_SET_RST 32'h00190021
`define FBO_ACTIVE_USED_MASK 32'h0007007f
`define FBO_SLAVE_STATE_RST 16'h0000
`define FBO_HM_ENABLE_RST 8'h01
`define FBO_HM_ON_BIT 0
`define FBO_BUS_STATE_LSB 0
`define FBO_ERR_BIT 4
`define FBO_SYNC_BIT 5
`define FBO_BS_INIT 4'h1
`define FBO_BS_PREOP 4'h2
`define FBO_BS_BOOT 4'h3
`define FBO_BS_SAFEOP 4'h4
`define FBO_BS_OP 4'h8
`define FBO_BIT_USB 0
`define FBO_BIT_RS485 1
`define FBO_BIT_RS232 2
`define FBO_BIT_CAN 3
`define FBO_BIT_ETHERNET_IF 4
`define FBO_BIT_INDUSTRIAL_SLAVE_IF 5
`define FBO_BIT_SPI 6
`define FBO_BIT_SERIAL_MODBUS_PROTO 16
`define FBO_BIT_TCP_MODBUS_PROTO 17
`define FBO_BIT_ETHERNET_INDUSTRIAL_PROTO 18
`endif

// >>> logic/fbo_slave_state.v
// packs the industrial slave state into the 16-bit slave status word
// assumes bus state, error and sync levels synchronous to i_mclk
`include "fbo_defs.vh"
module fbo_slave_state (
    input wire i_mclk,
    input wire i_reset_n,
    input wire i_ce,
    input wire [3:0] i_bus_state,
    input wire i_error,
    input wire i_sync,
    output reg [15:0] o_word
);
    // only documented codes pass; others keep the last legal state
    function legal_state;
        input [3:0] s;
        begin
            legal_state = (s == `FBO_BS_INIT) || (s == `FBO_BS_PREOP) ||
                (s == `FBO_BS_BOOT) || (s == `FBO_BS_SAFEOP) || (s == `FBO_BS_OP);
        end
    endfunction

    reg [3:0] bus_state_r;
    reg [15:0] word_nxt;

    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            bus_state_r <= 4'h0;
        else if (i_ce && legal_state(i_bus_state))
            bus_state_r <= i_bus_state; // see [R6]
    end

    always @*
    begin
        word_nxt = 16'h0000;
        word_nxt[`FBO_BUS_STATE_LSB +: 4] = legal_state(i_bus_state) ? i_bus_state
            : bus_state_r; // see [R6]
        word_nxt[`FBO_ERR_BIT] = i_error; // see [R7]
        word_nxt[`FBO_SYNC_BIT] = i_sync; // see [R8]
    end

    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_word <= `FBO_SLAVE_STATE_RST; // see [R5]
        else if (i_ce)
            o_word <= word_nxt;
    end
endmodule

// >>> logic/fbo_bank.v
// object-dictionary bank: fieldbus status array, slave status word, host motion entries
// assumes one object access per cycle from the fieldbus master or host, synchronous inputs
// narrow entries travel in the low bits of the 32-bit data words
// How it works
// [R1] deactivatable mask is read-only 32 bits, reset zero
// [R2] active-set word is read-only 32 bits, reset 00190021 hex
// [R3] both words share the interface/protocol bit layout; other bits unused; the active-set reset value still sets bits 19 and 20
// [R4] fieldbus status array reports highest subindex 2; mask at 1, active at 2
// [R5] slave status word is read-only 16 bits, reset zero
// [R6] 4-bit bus state field codes INIT 1, PREOP 2, BOOT 3, SAFEOP 4, OP 8
// [R7] error flag reads one while a slave error is active
// [R8] sync flag reads one while distributed-clock sync is active
// [R9] host sets bit 0 of 8-bit enable register to activate; reset 01
// [R10] host selects and starts operating modes via the command entry
// [R11] input record: highest subindex 4, signed 32/16/8 set values, 8-bit command
// [R12] active-set word follows fieldbuses switched by the separate control object
// [R13] writes to read-only entries are ignored
`include "fbo_defs.vh"
module fbo_bank (
    input wire i_mclk,
    input wire i_reset_n,
    input wire i_ce,
    input wire i_req,
    input wire i_wr,
    input wire [15:0] i_index,
    input wire [7:0] i_subindex,
    input wire [31:0] i_wdata,
    input wire [31:0] i_deact_capable,
    input wire [31:0] i_active_fieldbuses,
    input wire [3:0] i_bus_state,
    input wire i_slave_error,
    input wire i_dc_sync,
    output reg o_ack,
    output reg o_err,
    output reg [31:0] o_rdata,
    output reg [31:0] o_fieldbus_deactivatable_mask,
    output reg [31:0] o_fieldbus_active_set,
    output reg [15:0] o_slave_state_word,
    output reg o_host_motion_on,
    output reg [31:0] o_set_value_a,
    output reg [15:0] o_set_value_b,
    output reg [7:0] o_set_value_c,
    output reg [7:0] o_command,
    output reg o_command_strobe
);
    // what an object/subindex pair allows
    localparam [1:0] KIND_NONE = 2'b00;
    localparam [1:0] KIND_READ = 2'b01;
    localparam [1:0] KIND_WRITE = 2'b11;

    // access kind of an object/subindex pair; bit 0 mapped, bit 1 writable
    function [1:0] decode;
        input [15:0] idx;
        input [7:0] sub;
        begin
            decode = KIND_NONE;
            case (idx)
                `FBO_IDX_FB_STATUS:
                    if (sub <= `FBO_FB_STATUS_MAXSUB)
                        decode = KIND_READ; // see [R4]
                `FBO_IDX_SLAVE_STATE:
                    if (sub == `FBO_SUB_HIGHEST)
                        decode = KIND_READ;
                `FBO_IDX_HM_ENABLE:
                    if (sub == `FBO_SUB_HIGHEST)
                        decode = KIND_WRITE; // see [R9]
                `FBO_IDX_HM_INPUT:
                    if (sub == `FBO_SUB_HIGHEST)
                        decode = KIND_READ;
                    else if (sub <= `FBO_HM_INPUT_MAXSUB)
                        decode = KIND_WRITE; // see [R11]
                default:
                    decode = KIND_NONE;
            endcase
        end
    endfunction

    // one where a bit position carries an interface or protocol
    function layout_bit;
        input integer pos;
        begin
            case (pos)
                `FBO_BIT_USB,
                `FBO_BIT_RS485,
                `FBO_BIT_RS232,
                `FBO_BIT_CAN,
                `FBO_BIT_ETHERNET_IF,
                `FBO_BIT_INDUSTRIAL_SLAVE_IF,
                `FBO_BIT_SPI,
                `FBO_BIT_SERIAL_MODBUS_PROTO,
                `FBO_BIT_TCP_MODBUS_PROTO,
                `FBO_BIT_ETHERNET_INDUSTRIAL_PROTO:
                    layout_bit = 1'b1;
                default:
                    layout_bit = 1'b0;
            endcase
        end
    endfunction

    // signed 16-bit entry widened to the 32-bit read word
    function [31:0] sext16;
        input [15:0] v;
        begin
            sext16 = {{16{v[15]}}, v};
        end
    endfunction

    // signed 8-bit entry widened to the 32-bit read word
    function [31:0] sext8;
        input [7:0] v;
        begin
            sext8 = {{24{v[7]}}, v};
        end
    endfunction

    reg [7:0] hm_enable_r;
    reg [31:0] set_a_r;
    reg [15:0] set_b_r;
    reg [7:0] set_c_r;
    reg [7:0] command_r;
    reg [31:0] rdata_nxt;
    wire [1:0] dec = decode(i_index, i_subindex);
    wire hit = dec[0];
    wire wr_ok = i_req && i_wr && dec[1]; // see [R13]
    wire refused = !hit || (i_wr && !dec[1]); // see [R13]
    wire wr_input = wr_ok && (i_index == `FBO_IDX_HM_INPUT);
    wire wr_enable = wr_ok && (i_index == `FBO_IDX_HM_ENABLE);
    wire wr_set_a = wr_input && (i_subindex == `FBO_SUB_1);
    wire wr_set_b = wr_input && (i_subindex == `FBO_SUB_2);
    wire wr_set_c = wr_input && (i_subindex == `FBO_SUB_3);
    wire wr_command = wr_input && (i_subindex == `FBO_SUB_4);
    wire [15:0] slave_word;
    wire [31:0] active_masked;
    wire [31:0] deact_masked;

    // unused bit positions forced to zero in both words, except bits 19 and 20 of the active-set reset value
    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1)
        begin : g_layout
            assign active_masked[g] = layout_bit(g) ? i_active_fieldbuses[g] : 1'b0; // see [R3]
            assign deact_masked[g] = layout_bit(g) ? i_deact_capable[g] : 1'b0; // see [R3]
        end
    endgenerate

    fbo_slave_state fbo_slave_state_inst (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .i_bus_state(i_bus_state),
        .i_error(i_slave_error),
        .i_sync(i_dc_sync),
        .o_word(slave_word)
    );

    // deactivatable mask follows its source; no write path reaches it
    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_fieldbus_deactivatable_mask <= `FBO_DEACT_MASK_RST; // see [R1]
        else if (i_ce)
            o_fieldbus_deactivatable_mask <= deact_masked; // see [R1]
    end

    // active set follows the fieldbuses switched by the control object
    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_fieldbus_active_set <= `FBO_ACTIVE_SET_RST; // see [R2]
        else if (i_ce)
            o_fieldbus_active_set <= active_masked; // see [R12]
    end

    // writable host motion entries; each takes only its own object and subindex
    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            hm_enable_r <= `FBO_HM_ENABLE_RST; // see [R9]
        else if (i_ce && wr_enable)
            hm_enable_r <= i_wdata[7:0]; // see [R9]
    end

    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            set_a_r <= 32'h00000000; // see [R11]
        else if (i_ce && wr_set_a)
            set_a_r <= i_wdata; // see [R11]
    end

    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            set_b_r <= 16'h0000;
        else if (i_ce && wr_set_b)
            set_b_r <= i_wdata[15:0];
    end

    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            set_c_r <= 8'h00;
        else if (i_ce && wr_set_c)
            set_c_r <= i_wdata[7:0];
    end

    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            command_r <= 8'h00;
        else if (i_ce && wr_command)
            command_r <= i_wdata[7:0]; // see [R10]
    end

    // strobe marks the cycle after a command write
    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_command_strobe <= 1'b0;
        else if (i_ce)
            o_command_strobe <= wr_command; // see [R10]
    end

    // read mux; the narrower set values and the 8-bit command sign-extend, enable and top subindex zero-extend
    always @*
    begin
        rdata_nxt = 32'h00000000;
        case (i_index)
            `FBO_IDX_FB_STATUS:
                case (i_subindex)
                    `FBO_SUB_HIGHEST: rdata_nxt = {24'h000000, `FBO_FB_STATUS_MAXSUB}; // see [R4]
                    `FBO_SUB_1: rdata_nxt = o_fieldbus_deactivatable_mask; // see [R4]
                    `FBO_SUB_2: rdata_nxt = o_fieldbus_active_set;
                    default: rdata_nxt = 32'h00000000;
                endcase
            `FBO_IDX_SLAVE_STATE:
                rdata_nxt = {16'h0000, slave_word};
            `FBO_IDX_HM_ENABLE:
                rdata_nxt = {24'h000000, hm_enable_r};
            `FBO_IDX_HM_INPUT:
                case (i_subindex)
                    `FBO_SUB_HIGHEST: rdata_nxt = {24'h000000, `FBO_HM_INPUT_MAXSUB}; // see [R11]
                    `FBO_SUB_1: rdata_nxt = set_a_r;
                    `FBO_SUB_2: rdata_nxt = sext16(set_b_r);
                    `FBO_SUB_3: rdata_nxt = sext8(set_c_r);
                    `FBO_SUB_4: rdata_nxt = sext8(command_r);
                    default: rdata_nxt = 32'h00000000;
                endcase
            default:
                rdata_nxt = 32'h00000000;
        endcase
        if (!hit)
            rdata_nxt = 32'h00000000;
    end

    // one-cycle answer; refused accesses flag o_err
    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_ack <= 1'b0;
            o_err <= 1'b0;
        end
        else if (i_ce)
        begin
            o_ack <= i_req;
            o_err <= i_req && refused; // see [R13]
        end
    end

    // read data stands with o_ack only; writes and idle cycles answer zero
    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_rdata <= 32'h00000000;
        else if (i_ce)
            o_rdata <= (i_req && !i_wr) ? rdata_nxt : 32'h00000000;
    end

    // slave word mirror adds one cycle behind the packing stage
    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_slave_state_word <= `FBO_SLAVE_STATE_RST; // see [R5]
        else if (i_ce)
            o_slave_state_word <= slave_word; // see [R5]
    end

    // host motion mirrors drive outputs straight from flip-flops
    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_host_motion_on <= 1'b1;
            o_set_value_a <= 32'h00000000;
            o_set_value_b <= 16'h0000;
            o_set_value_c <= 8'h00;
            o_command <= 8'h00;
        end
        else if (i_ce)
        begin
            o_host_motion_on <= hm_enable_r[`FBO_HM_ON_BIT]; // see [R9]
            o_set_value_a <= set_a_r;
            o_set_value_b <= set_b_r;
            o_set_value_c <= set_c_r;
            o_command <= command_r;
        end
    end
endmodule

// >>> dv/fbo_bank_props.sv
// port checker for the fieldbus/host motion object bank
// assumes it is bound to the bank's top module and sees its ports by name
module fbo_bank_props (
    input wire i_mclk,
    input wire i_reset_n,
    input wire i_ce,
    input wire i_req,
    input wire i_wr,
    input wire [15:0] i_index,
    input wire [7:0] i_subindex,
    input wire [31:0] i_wdata,
    input wire [31:0] i_deact_capable,
    input wire [31:0] i_active_fieldbuses,
    input wire [3:0] i_bus_state,
    input wire i_slave_error,
    input wire i_dc_sync,
    input wire o_ack,
    input wire o_err,
    input wire [31:0] o_rdata,
    input wire [31:0] o_fieldbus_deactivatable_mask,
    input wire [31:0] o_fieldbus_active_set,
    input wire [15:0] o_slave_state_word,
    input wire o_host_motion_on,
    input wire [7:0] o_command,
    input wire o_command_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    wire wr_go = i_ce && i_req && i_wr;
    wire rd_go = i_ce && i_req && !i_wr;
    wire [23:0] at = {i_index, i_subindex};
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    mask_follow_a:
        assert property (i_ce |=> o_fieldbus_deactivatable_mask
            == ($past(i_deact_capable) & 32'h0007007f)) else $error("mask not following");
    active_follow_a:
        assert property (i_ce |=> o_fieldbus_active_set
            == ($past(i_active_fieldbuses) & 32'h0007007f)) else $error("active set wrong");
    slave_word_a:
        assert property (i_ce ##1 i_ce |=> o_slave_state_word == {10'h0, $past(i_dc_sync, 2),
            $past(i_slave_error, 2), $past(i_bus_state, 2)}) else $error("slave word wrong");
    ro_refuse_a:
        assert property (wr_go && (i_index == 16'h2103 || i_index == 16'h2110)
            |=> o_ack && o_err) else $error("read-only write not refused");
    fb_maxsub_a:
        assert property (rd_go && at == 24'h210300 |=> o_rdata == 32'h2 && !o_err)
            else $error("status array top subindex wrong");
    in_maxsub_a:
        assert property (rd_go && at == 24'h229100 |=> o_rdata == 32'h4 && !o_err)
            else $error("input record top subindex wrong");
    cmd_strobe_a:
        assert property (wr_go && at == 24'h229104 |=> o_command_strobe ##1
            o_command == $past(i_wdata[7:0], 2)) else $error("command write lost");
    hm_enable_a:
        assert property (wr_go && at == 24'h229000 ##1 !(wr_go && i_index == 16'h2290)
            |=> o_host_motion_on == $past(i_wdata[0], 2)) else $error("enable bit not stored");
endmodule

bind fbo_bank fbo_bank_props fbo_bank_props_inst (.*);

// >>> dv/fbo_host.sv
// host model issuing object reads and writes to the bank
// assumes each access is started at a falling edge of i_mclk
module fbo_host (
    input wire i_mclk,
    input wire o_ack,
    input wire o_err,
    input wire [31:0] o_rdata,
    output logic i_req = 1'b0,
    output logic i_wr = 1'b0,
    output logic [15:0] i_index = 16'h0,
    output logic [7:0] i_subindex = 8'h0,
    output logic [31:0] i_wdata = 32'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] wd, output logic ack, output logic err, output logic [31:0] rd);
        i_req = 1'b1;
        i_wr = wr;
        i_index = idx;
        i_subindex = sub;
        i_wdata = wr ? wd : ~i_wdata;
        @(negedge i_mclk);
        ack = o_ack;
        err = o_err;
        rd = o_rdata;
    endtask
    // released index and data lines show a changing pattern; i_wr and i_subindex keep their last value
    task automatic idle;
        i_req = 1'b0;
        i_index = ~i_index;
        i_wdata = ~i_wdata;
    endtask
endmodule

// >>> dv/fbo_bank_test.sv
// self-checking bench for the fieldbus/host motion object bank
// assumes the bank, its checker and the host model are compiled alongside
module fbo_bank_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 1'b0, i_reset_n = 1'b0, i_ce = 1'b1, i_slave_error = 1'b0, i_dc_sync = 1'b0;
    logic i_req, i_wr, o_ack, o_err, o_host_motion_on, o_command_strobe, ack, err;
    logic [3:0] i_bus_state = 4'h1;
    logic [7:0] i_subindex, o_set_value_c, o_command, svc = 8'h0, cmd = 8'h0, en = 8'h01;
    logic [15:0] i_index, o_slave_state_word, o_set_value_b, svb = 16'h0;
    logic [31:0] i_wdata, o_rdata, rd, o_fieldbus_deactivatable_mask, o_fieldbus_active_set;
    logic [31:0] o_set_value_a, sva = 32'h0, i_deact_capable = 32'h0, i_active_fieldbuses = 32'h0;
    logic [3:0] bs_tab [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
    logic [15:0] idx_tab [5] = '{16'h2103, 16'h2110, 16'h2290, 16'h2291, 16'h2100};
    int errors = 0;
    int tests_run = 0;
    fbo_bank fbo_bank_inst (.*);
    fbo_host fbo_host_inst (.*);
    initial forever #10 i_mclk = ~i_mclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results;
        if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [32:0] exp_rd(input logic [15:0] idx, input logic [7:0] sub);
        case ({idx, sub})
            24'h210300: return {1'b0, 32'h2};
            24'h210301: return {1'b0, i_deact_capable & 32'h0007007f};
            24'h210302: return {1'b0, i_active_fieldbuses & 32'h0007007f};
            24'h211000: return {1'b0, 26'h0, i_dc_sync, i_slave_error, i_bus_state};
            24'h229000: return {25'h0, en};
            24'h229100: return {1'b0, 32'h4};
            24'h229101: return {1'b0, sva};
            24'h229102: return {1'b0, {16{svb[15]}}, svb};
            24'h229103: return {1'b0, {24{svc[7]}}, svc};
            24'h229104: return {1'b0, {24{cmd[7]}}, cmd};
            default: return {1'b1, 32'h0};
        endcase
    endfunction
    task automatic op(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] wd);
        logic ok;
        logic [32:0] e;
        ok = idx == 16'h2290 ? sub == 8'h00 : idx == 16'h2291 && sub inside {[8'h01:8'h04]};
        e = exp_rd(idx, sub);
        fbo_host_inst.access(wr, idx, sub, wd, ack, err, rd);
        check(ack, 1'b1);
        check(err, wr ? !ok : e[32]);
        if (!wr && !e[32])
            check(rd, e[31:0]);
        if (wr && ok)
            case (sub)
                8'h00: en = wd[7:0];
                8'h01: sva = wd;
                8'h02: svb = wd[15:0];
                8'h03: svc = wd[7:0];
                default: cmd = wd[7:0];
            endcase
    endtask
    task automatic settle;
        fbo_host_inst.idle();
        @(negedge i_mclk);
        check(o_set_value_a, sva);
        check({o_set_value_b, o_set_value_c, o_command}, {svb, svc, cmd});
        check(o_host_motion_on, en[0]);
    endtask
    initial
    begin
        void'($urandom(76339));
        repeat (16) @(posedge i_mclk);
        check(o_fieldbus_deactivatable_mask, 32'h0);
        check(o_fieldbus_active_set, 32'h00190021);
        check(o_slave_state_word, 32'h0);
        check(o_set_value_a, 32'h0);
        check({o_set_value_b, o_set_value_c, o_command}, 32'h0);
        check(o_host_motion_on, 1'b1);
        @(negedge i_mclk);
        i_reset_n = 1'b1;
        op(1'b1, 16'h2291, 8'h04, 32'h000000fb);
        op(1'b0, 16'h2291, 8'h04, 32'h0);
        op(1'b1, 16'h2110, 8'h00, 32'h0000ffff);
        op(1'b1, 16'h2290, 8'h00, 32'h0);
        op(1'b0, 16'h2290, 8'h00, 32'h0);
        i_ce = 1'b0;
        fbo_host_inst.access(1'b1, 16'h2291, 8'h01, 32'h5a5a5a5a, ack, err, rd);
        i_ce = 1'b1;
        op(1'b0, 16'h2291, 8'h01, 32'h0);
        settle();
        repeat (30)
        begin
            i_deact_capable = $urandom;
            i_active_fieldbuses = $urandom;
            i_bus_state = bs_tab[$urandom % 5];
            i_slave_error = 1'($urandom);
            i_dc_sync = 1'($urandom);
            repeat (3) @(negedge i_mclk);
            repeat (8)
                op(1'($urandom), idx_tab[$urandom % 5], 8'($urandom % 6), $urandom);
            settle();
        end
        results();
    end
    initial
    begin
        #200000;
        errors++;
        results();
    end
endmodule
